// ### rtl/nsx_datapath.sv
`timescale 1ns/1ps
// What this block does
// - Swap exchanges the file register nibbles; no status flag changes.
// - File operand is a 5-bit address; destination 0 is work, 1 is file.
// - Direction load copies work into direction register 6 or 7; no flags.
// - File XOR combines work and file, routes by destination, only zero flag.
// - Literal XOR combines an 8-bit immediate with work by bitwise XOR.
module nsx_datapath
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Decoded instruction, one per valid cycle
    input wire logic reqValid,
    input wire nsx_pkg::nsx_req_t req,
    // Combinational read port of the register file
    output logic [nsx_pkg::FADDR_W-1:0] fileRdAddr,
    input wire logic [nsx_pkg::DATA_W-1:0] fileRdData,
    // Results
    output nsx_pkg::nsx_wb_t wb,
    output logic [nsx_pkg::DATA_W-1:0] work,
    output logic [nsx_pkg::DATA_W-1:0] dirA,
    output logic [nsx_pkg::DATA_W-1:0] dirB,
    output logic badDirSel
);
    import nsx_pkg::*;

    // Whole datapath state and its next value
    nsx_state_t state;
    nsx_state_t next_state;

    // Decoded view of the current request
    logic accept;
    logic resultToFile;
    logic [DATA_W-1:0] opResult;

    ////////////////////////////////////////////////////////////////////////////

    // Helpers shared by the next-state logic and the decoder flag
    function automatic logic [DATA_W-1:0] swapNib(input logic [DATA_W-1:0] v);
        swapNib = {v[NIB_LO_MSB:0], v[DATA_W-1:NIB_HI_LSB]};
    endfunction : swapNib

    function automatic logic isZero(input logic [DATA_W-1:0] v);
        isZero = (v == 8'h00);
    endfunction : isZero

    // Only the two direction selectors are honoured
    function automatic logic isDirSel(input logic [FADDR_W-1:0] sel);
        isDirSel = (sel == DIR_SEL_LO) || (sel == DIR_SEL_HI);
    endfunction : isDirSel

    // Operations whose result follows the destination select
    function automatic logic usesDest(input nsx_op_t op);
        usesDest = (op == NSX_OP_SWAP) || (op == NSX_OP_XORF);
    endfunction : usesDest

    // Result of the current operation; zero for operations without one
    function automatic logic [DATA_W-1:0] opValue
    (
        input nsx_op_t op,
        input logic [DATA_W-1:0] w,
        input logic [DATA_W-1:0] f,
        input logic [DATA_W-1:0] lit
    );
        opValue = '0;
        unique case (op)
            NSX_OP_SWAP:
            begin
                opValue = swapNib(f);
            end

            NSX_OP_XORL:
            begin
                opValue = w ^ lit;
            end

            NSX_OP_XORF:
            begin
                opValue = w ^ f;
            end

            default:
            begin
                opValue = '0;
            end
        endcase
    endfunction : opValue

    ////////////////////////////////////////////////////////////////////////////

    // Requests wait for the synchronised reset release
    assign accept = state.rstSync && reqValid;

    // Read address follows the request so the operand is ready this cycle
    assign fileRdAddr = req.fileAddr;

    // Work is read from its register: no bypass is needed back to back
    assign opResult = opValue(req.op, state.work, fileRdData, req.literal);
    assign resultToFile = usesDest(req.op) && (req.dest == DEST_FILE);

    ////////////////////////////////////////////////////////////////////////////

    // One request is committed per accepted edge
    always_comb
    begin
        // Hold everything not written below
        next_state = state;

        // Two-stage release of the reset
        next_state.rstMeta = 1'b1;
        next_state.rstSync = state.rstMeta;

        // Write-back strobes are one-cycle pulses
        next_state.wb = '0;
        next_state.wb.fileAddr = req.fileAddr;
        if (accept)
        begin
            unique case (req.op)
                NSX_OP_NONE:
                begin
                    // Idle slot, nothing to commit
                end

                NSX_OP_SWAP:
                begin
                    // No flag is written by a swap
                    if (resultToFile)
                    begin
                        next_state.wb.fileWe = 1'b1;
                        next_state.wb.fileData = opResult;
                    end
                    else
                    begin
                        next_state.work = opResult;
                    end
                end

                NSX_OP_DIR:
                begin
                    // Other selectors are dropped and flagged to the decoder
                    if (isDirSel(req.fileAddr))
                    begin
                        if (req.fileAddr == DIR_SEL_LO)
                        begin
                            next_state.dirA = state.work;
                        end
                        else
                        begin
                            next_state.dirB = state.work;
                        end
                    end
                end

                NSX_OP_XORL:
                begin
                    // The destination bit is ignored here
                    next_state.work = opResult;
                    next_state.wb.zeroWe = 1'b1;
                    next_state.wb.zero = isZero(opResult);
                end

                NSX_OP_XORF:
                begin
                    // Result goes where the destination bit points
                    if (resultToFile)
                    begin
                        next_state.wb.fileWe = 1'b1;
                        next_state.wb.fileData = opResult;
                    end
                    else
                    begin
                        next_state.work = opResult;
                    end
                    // Zero is the only flag this operation touches
                    next_state.wb.zeroWe = 1'b1;
                    next_state.wb.zero = isZero(opResult);
                end

                default:
                begin
                    // Illegal codes are dropped with no side effect
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Clear is asynchronous; release is seen through rstMeta and rstSync
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state.rstMeta <= 1'b0;
            state.rstSync <= 1'b0;
            state.work <= WORK_RST;
            state.dirA <= DIR_RST;
            state.dirB <= DIR_RST;
            state.wb <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Data outputs straight from the state flip-flops
    assign wb = state.wb;
    assign work = state.work;
    assign dirA = state.dirA;
    assign dirB = state.dirB;

    // Flag for the decoder: a direction load with an unknown selector
    assign badDirSel = reqValid && (req.op == NSX_OP_DIR)
        && !isDirSel(req.fileAddr);

endmodule : nsx_datapath

// ### rtl/nsx_pkg.sv
package nsx_pkg;

    localparam int DATA_W = 8;
    localparam int FADDR_W = 5;

    // Destination select values
    localparam logic DEST_WORK = 1'h0;
    localparam logic DEST_FILE = 1'h1;

    // Direction register selectors accepted by the load
    localparam logic [FADDR_W-1:0] DIR_SEL_LO = 5'h06;
    localparam logic [FADDR_W-1:0] DIR_SEL_HI = 5'h07;

    // Nibble field positions
    localparam int NIB_LO_MSB = 3;
    localparam int NIB_HI_LSB = 4;

    // Reset values
    localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
    localparam logic [DATA_W-1:0] DIR_RST = 8'hFF;

    typedef enum logic [2:0]
    {
        NSX_OP_NONE = 3'b000,
        NSX_OP_SWAP = 3'b001,
        NSX_OP_DIR = 3'b010,
        NSX_OP_XORL = 3'b011,
        NSX_OP_XORF = 3'b100
    } nsx_op_t;

    // Request from the decoder
    typedef struct packed
    {
        nsx_op_t op;
        logic [FADDR_W-1:0] fileAddr;
        logic dest;
        logic [DATA_W-1:0] literal;
    } nsx_req_t;

    // Write-back toward the register file
    typedef struct packed
    {
        logic fileWe;
        logic [FADDR_W-1:0] fileAddr;
        logic [DATA_W-1:0] fileData;
        logic zeroWe;
        logic zero;
    } nsx_wb_t;

    // All state of the datapath
    typedef struct packed
    {
        logic rstMeta;
        logic rstSync;
        logic [DATA_W-1:0] work;
        logic [DATA_W-1:0] dirA;
        logic [DATA_W-1:0] dirB;
        nsx_wb_t wb;
    } nsx_state_t;

endpackage : nsx_pkg

// ### test/nsx_props.sv
`timescale 1ns/1ps
module nsx_props
(
    // Watched ports
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic reqValid,
    input wire nsx_pkg::nsx_req_t req,
    input wire logic [nsx_pkg::FADDR_W-1:0] fileRdAddr,
    input wire logic [nsx_pkg::DATA_W-1:0] fileRdData,
    input wire nsx_pkg::nsx_wb_t wb,
    input wire logic [nsx_pkg::DATA_W-1:0] work,
    input wire logic [nsx_pkg::DATA_W-1:0] dirA,
    input wire logic [nsx_pkg::DATA_W-1:0] dirB,
    input wire logic badDirSel
);
    import nsx_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    swap_nibble_a: assert property (reqValid && req.op == NSX_OP_SWAP && req.dest
        |=> wb.fileWe && !wb.zeroWe && wb.fileData == {$past(fileRdData[3:0]),
        $past(fileRdData[7:4])}) else $error("swap result wrong");
    rd_addr_a: assert property (fileRdAddr == req.fileAddr) else $error("read address");
    dir_load_a: assert property (reqValid && req.op == NSX_OP_DIR && req.fileAddr == 5'h06
        |=> dirA == $past(work) && !wb.zeroWe) else $error("direction load wrong");
    xor_file_a: assert property (reqValid && req.op == NSX_OP_XORF |=> wb.zeroWe
        && wb.fileWe == $past(req.dest)) else $error("file xor routing wrong");
    xor_lit_a: assert property (reqValid && req.op == NSX_OP_XORL
        |=> work == ($past(work) ^ $past(req.literal))) else $error("literal xor wrong");
    xor_zero_a: assert property (reqValid && req.op == NSX_OP_XORL
        |=> wb.zeroWe && !wb.fileWe && wb.zero == (work == 8'h00)) else $error("zero flag");
    swap_work_a: assert property (reqValid && req.op == NSX_OP_SWAP && !req.dest
        |=> work == {$past(fileRdData[3:0]), $past(fileRdData[7:4])} && !wb.fileWe
        && !wb.zeroWe) else $error("swap to work wrong");
    dir_hi_a: assert property (reqValid && req.op == NSX_OP_DIR
        && req.fileAddr == 5'h07 |=> dirB == $past(work) && !wb.zeroWe)
        else $error("high direction load wrong");
    bad_sel_a: assert property (badDirSel |=> dirA == $past(dirA)
        && dirB == $past(dirB) && work == $past(work)) else $error("bad selector changed state");
    cover property (wb.zeroWe && wb.zero);
    cover property (badDirSel);
    cover property (wb.fileWe);
endmodule : nsx_props
bind nsx_datapath nsx_props u_props
(
    .ref_clk(ref_clk),
    .rstn(rstn),
    .reqValid(reqValid),
    .req(req),
    .fileRdAddr(fileRdAddr),
    .fileRdData(fileRdData),
    .wb(wb),
    .work(work),
    .dirA(dirA),
    .dirB(dirB),
    .badDirSel(badDirSel)
);

// ### test/nsx_rf_model.sv
`timescale 1ns/1ps
module nsx_rf_model
(
    // Register file side
    input wire logic ref_clk,
    input wire nsx_pkg::nsx_wb_t wb,
    input wire logic [nsx_pkg::FADDR_W-1:0] fileRdAddr,
    output logic [nsx_pkg::DATA_W-1:0] fileRdData
);
    import nsx_pkg::*;
    logic [DATA_W-1:0] mem [32];
    initial for (int i = 0; i < 32; i++) mem[i] = DATA_W'(i * 59);
    assign fileRdData = mem[fileRdAddr];
    // Plain always: the array is also preset by the initial block
    always @(posedge ref_clk) if (wb.fileWe) mem[wb.fileAddr] <= wb.fileData;
endmodule : nsx_rf_model

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import nsx_pkg::*;
    logic ref_clk = 0, rstn = 0, reqValid = 0, badDirSel, fw, zw, bs;
    nsx_req_t req = '0;
    nsx_wb_t wb;
    logic [FADDR_W-1:0] fileRdAddr;
    logic [DATA_W-1:0] fileRdData, work, dirA, dirB, f, res;
    logic [DATA_W-1:0] ew = WORK_RST, ea = DIR_RST, eb = DIR_RST;
    logic [31:0] rnd = 32'h8B8F6664;
    int err_total = 0, n_tests = 0, cyc = 0;
    nsx_datapath dut
    (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .reqValid(reqValid),
        .req(req),
        .fileRdAddr(fileRdAddr),
        .fileRdData(fileRdData),
        .wb(wb),
        .work(work),
        .dirA(dirA),
        .dirB(dirB),
        .badDirSel(badDirSel)
    );
    nsx_rf_model u_rf
    (
        .ref_clk(ref_clk),
        .wb(wb),
        .fileRdAddr(fileRdAddr),
        .fileRdData(fileRdData)
    );
    initial forever #20 ref_clk = ~ref_clk;
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic logic [7:0] exp_res(nsx_req_t q, logic [7:0] w, logic [7:0] v);
        case (q.op)
            NSX_OP_SWAP: return {v[3:0], v[7:4]};
            NSX_OP_XORF: return w ^ v;
            default: return w ^ q.literal;
        endcase
    endfunction : exp_res
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done
    // Hang guard, run needs about 420 cycles
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_total++;
            test_done();
        end
    end
    initial
    begin
        repeat (16) @(negedge ref_clk);
        rstn = 1;
        repeat (3) @(negedge ref_clk);
        for (int i = 0; i < 400; i++)
        begin
            rnd = lfsr_next(rnd);
            reqValid = rnd[31:29] != 3'h0;
            // Codes 5 to 7 are illegal and must be ignored
            req = nsx_req_t'(rnd[16:0]);
            if (req.op == NSX_OP_DIR) req.fileAddr = 5'h05 + 5'(rnd[25:24]);
            if (i % 8 == 0) req.literal = ew;
            #1;
            f = fileRdData;
            res = exp_res(req, ew, f);
            chk("rdAddr", 8'(req.fileAddr), 8'(fileRdAddr));
            bs = reqValid && req.op == NSX_OP_DIR
                && req.fileAddr != DIR_SEL_LO && req.fileAddr != DIR_SEL_HI;
            chk("badSel", 8'(bs), 8'(badDirSel));
            @(negedge ref_clk);
            fw = reqValid && req.dest && req.op inside {NSX_OP_SWAP, NSX_OP_XORF};
            zw = reqValid && req.op inside {NSX_OP_XORL, NSX_OP_XORF};
            if (reqValid && req.op == NSX_OP_DIR && req.fileAddr == DIR_SEL_LO) ea = ew;
            if (reqValid && req.op == NSX_OP_DIR && req.fileAddr == DIR_SEL_HI) eb = ew;
            if (reqValid && (req.op == NSX_OP_XORL
                || (!req.dest && req.op inside {NSX_OP_SWAP, NSX_OP_XORF})))
                ew = res;
            chk("fileWe", 8'(fw), 8'(wb.fileWe));
            if (fw) chk("fileAddr", 8'(req.fileAddr), 8'(wb.fileAddr));
            if (fw) chk("fileData", res, wb.fileData);
            chk("zeroWe", 8'(zw), 8'(wb.zeroWe));
            if (zw) chk("zero", 8'(res == 8'h00), 8'(wb.zero));
            chk("work", ew, work);
            chk("dirA", ea, dirA);
            chk("dirB", eb, dirB);
        end
        test_done();
    end
endmodule : tb_top
